// ==== rgc_pkg.sv ====
package rgc_pkg;
  // ----------------------------------------
  // Register byte addresses (offset times four, printed offsets are word indices)
  // ----------------------------------------
  localparam logic [15:0] RGC_IDX_BIT_SYNC   = 16'hdf16;
  localparam logic [15:0] RGC_IDX_GAIN_LIMIT = 16'hdf17;
  localparam logic [15:0] RGC_IDX_PRIO_CS    = 16'hdf18;
  localparam logic [17:0] RGC_ADDR_BIT_SYNC   = {RGC_IDX_BIT_SYNC, 2'b00};
  localparam logic [17:0] RGC_ADDR_GAIN_LIMIT = {RGC_IDX_GAIN_LIMIT, 2'b00};
  localparam logic [17:0] RGC_ADDR_PRIO_CS    = {RGC_IDX_PRIO_CS, 2'b00};
  localparam int          RGC_ADDR_W          = 18;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RGC_RST_BIT_SYNC   = 8'h6c;
  localparam logic [7:0] RGC_RST_GAIN_LIMIT = 8'h03;
  localparam logic [7:0] RGC_RST_PRIO_CS    = 8'h40;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RGC_DG_LSB   = 6;
  localparam int RGC_AG_LSB   = 3;
  localparam int RGC_TGT_LSB  = 0;
  localparam int RGC_PRIO_BIT = 6;
  localparam int RGC_REL_LSB  = 4;
  localparam int RGC_ABS_LSB  = 0;
  localparam logic [7:0] RGC_PRIO_CS_MASK = 8'h7f;
  // ----------------------------------------
  // Field codes
  // ----------------------------------------
  localparam logic [3:0] RGC_ABS_DISABLE = 4'h8;
  localparam logic [1:0] RGC_REL_OFF     = 2'h0;
  localparam logic [2:0] RGC_DG_STEPS    = 3'h7;
  localparam logic [3:0] RGC_REL_DB1     = 4'h6;
  localparam logic [3:0] RGC_REL_DB2     = 4'ha;
  localparam logic [3:0] RGC_REL_DB3     = 4'he;
  typedef logic [7:0] rgc_db_t;
endpackage

// ==== rgc_target_rom.sv ====
`timescale 1ns/1ps
// Amplitude target lookup, registered output
module rgc_target_rom
  import rgc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // Lookup
  input  wire logic [2:0] code_i,
  output rgc_db_t         target_db_o
);
  rgc_db_t table_db [8];
  assign table_db[0] = 8'h18;
  assign table_db[1] = 8'h1b;
  assign table_db[2] = 8'h1e;
  assign table_db[3] = 8'h21;
  assign table_db[4] = 8'h24;
  assign table_db[5] = 8'h26;
  assign table_db[6] = 8'h28;
  assign table_db[7] = 8'h2a;
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      target_db_o <= 8'h00;
    else
      target_db_o <= table_db[code_i];
  end
endmodule

// ==== rgc_top.sv ====
`timescale 1ns/1ps
// Overview of operation
// R1: Digital gain ceiling code removes the top zero to three digital gain steps.
// R2: Amplifier gain ceiling code steps combined front gain down; 000 is full.
// R3: Amplitude target code maps to 24,27,30,33,36,38,40,42 dB.
// R4: Priority one reduces first amplifier first; zero drains second amplifier first.
// R5: Relative sense asserts on 6, 10 or 14 dB rise; code 00 disables.
// R6: Carrier sense asserts when strength reading reaches absolute threshold.
// R7: Absolute threshold is signed 1 dB offset from the amplitude target.
// R8: Absolute code 1000 disables absolute sensing.
// R9: Other absolute codes give offsets minus seven to plus seven dB.
// R10: Top bit of carrier sense register reads zero and ignores writes.
module rgc_top
  import rgc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  // APB slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [RGC_ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // Gain loop side
  input  wire logic [7:0]            strength_db_i,
  input  wire logic [7:0]            strength_ref_db_i,
  output logic      [2:0]            digital_gain_max_step_o,
  output logic      [2:0]            amplifier_gain_ceiling_o,
  output logic                       stage_reduction_priority_o,
  output logic      [7:0]            amplitude_target_db_o,
  output logic                       carrier_sense_o
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  bit_sync_config;
    logic [7:0]  gain_limit_target;
    logic [7:0]  gain_priority_carrier_sense;
    logic [31:0] rdata;
    logic        err;
    logic [2:0]  dg_max;
    logic        abs_hit;
    logic        rel_hit;
    logic        cs;
  } rgc_state_s;
  rgc_state_s s_q;
  rgc_state_s s_d;
  rgc_db_t    target_db;
  logic       access;
  logic       setup;
  logic       known;
  logic [7:0] rd_byte;
  logic [3:0] abs_code;
  logic [1:0] rel_code;
  logic [8:0] abs_level;
  logic [8:0] rel_level;
  logic [3:0] rel_db;

  rgc_target_rom u_rom (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .code_i      (s_q.gain_limit_target[RGC_TGT_LSB +: 3]), // R3
    .target_db_o (target_db)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_d      = s_q;
    access   = psel_i && penable_i;
    setup    = psel_i && !penable_i;
    known    = (paddr_i == RGC_ADDR_BIT_SYNC) || (paddr_i == RGC_ADDR_GAIN_LIMIT) || (paddr_i == RGC_ADDR_PRIO_CS);
    rd_byte  = 8'h00;
    abs_code = s_q.gain_priority_carrier_sense[RGC_ABS_LSB +: 4];
    rel_code = s_q.gain_priority_carrier_sense[RGC_REL_LSB +: 2];
    case (rel_code)
      2'h1:    rel_db = RGC_REL_DB1; // R5
      2'h2:    rel_db = RGC_REL_DB2; // R5
      default: rel_db = RGC_REL_DB3; // R5
    endcase
    // Sign-extend the offset onto the target; nine bits keep negative sums from wrapping
    abs_level = 9'({1'b0, target_db}) + {{5{abs_code[3]}}, abs_code}; // R7 R9
    rel_level = 9'({1'b0, strength_ref_db_i}) + 9'({5'h00, rel_db});
    case (paddr_i)
      RGC_ADDR_BIT_SYNC:   rd_byte = s_q.bit_sync_config;
      RGC_ADDR_GAIN_LIMIT: rd_byte = s_q.gain_limit_target;
      RGC_ADDR_PRIO_CS:    rd_byte = s_q.gain_priority_carrier_sense & RGC_PRIO_CS_MASK; // R10
      default:             rd_byte = 8'h00;
    endcase
    // Answer is captured in the setup cycle so it already stands when the zero-wait access edge takes it
    if (setup)
    begin
      s_d.err   = !known;
      s_d.rdata = (!pwrite_i && known) ? {24'h000000, rd_byte} : 32'h00000000;
    end
    if (access && pwrite_i)
    begin
      case (paddr_i)
        RGC_ADDR_BIT_SYNC:   s_d.bit_sync_config = pwdata_i[7:0];
        RGC_ADDR_GAIN_LIMIT: s_d.gain_limit_target = pwdata_i[7:0];
        RGC_ADDR_PRIO_CS:    s_d.gain_priority_carrier_sense = pwdata_i[7:0] & RGC_PRIO_CS_MASK; // R10
        default:             s_d.err = 1'b1;
      endcase
    end
    // Highest usable digital step shrinks by the ceiling code
    s_d.dg_max  = RGC_DG_STEPS - {1'b0, s_q.gain_limit_target[RGC_DG_LSB +: 2]}; // R1
    // A negative threshold clamps to zero so any reading meets it
    s_d.abs_hit = (abs_code != RGC_ABS_DISABLE) && // R8
                  (abs_level[8] || ({1'b0, strength_db_i} >= abs_level)); // R6
    s_d.rel_hit = (rel_code != RGC_REL_OFF) && ({1'b0, strength_db_i} >= rel_level); // R5
    s_d.cs      = s_q.abs_hit || s_q.rel_hit; // R6
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_q <= '0;
      s_q.bit_sync_config <= RGC_RST_BIT_SYNC;
      s_q.gain_limit_target <= RGC_RST_GAIN_LIMIT;
      s_q.gain_priority_carrier_sense <= RGC_RST_PRIO_CS;
      s_q.dg_max <= RGC_DG_STEPS;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign pready_o                   = 1'b1;
  assign prdata_o                   = s_q.rdata;
  assign pslverr_o                  = s_q.err;
  assign digital_gain_max_step_o    = s_q.dg_max;
  assign amplifier_gain_ceiling_o   = s_q.gain_limit_target[RGC_AG_LSB +: 3]; // R2
  assign stage_reduction_priority_o = s_q.gain_priority_carrier_sense[RGC_PRIO_BIT]; // R4
  assign amplitude_target_db_o      = target_db;
  assign carrier_sense_o            = s_q.cs;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_top_bit;
    @(posedge clk_i) disable iff (!reset_n_i)
    s_q.gain_priority_carrier_sense[7] == 1'b0;
  endproperty
  a_top_bit: assert property (p_top_bit) else $error("carrier sense top bit set"); // R10

  property p_abs_off;
    @(posedge clk_i) disable iff (!reset_n_i)
    (abs_code == RGC_ABS_DISABLE && rel_code == RGC_REL_OFF) [*2] |=> !carrier_sense_o;
  endproperty
  a_abs_off: assert property (p_abs_off) else $error("sense with both detectors off"); // R8

  property p_dg;
    @(posedge clk_i) disable iff (!reset_n_i)
    $stable(s_q.gain_limit_target) |=> digital_gain_max_step_o == 3'(7 - $past(s_q.gain_limit_target[7:6]));
  endproperty
  a_dg: assert property (p_dg) else $error("digital ceiling wrong"); // R1

  property p_tgt;
    @(posedge clk_i) disable iff (!reset_n_i)
    $stable(s_q.gain_limit_target) && s_q.gain_limit_target[2:0] == 3'h0 |=> amplitude_target_db_o == 8'h18;
  endproperty
  a_tgt: assert property (p_tgt) else $error("target not 24 dB"); // R3

  property p_rd;
    @(posedge clk_i) disable iff (!reset_n_i)
    psel_i && penable_i && !pwrite_i && paddr_i == RGC_ADDR_GAIN_LIMIT
      |-> prdata_o == {24'h000000, s_q.gain_limit_target};
  endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");

  property p_abs_hit;
    @(posedge clk_i) disable iff (!reset_n_i)
    abs_code == 4'h0 && strength_db_i >= target_db |=> ##1 carrier_sense_o;
  endproperty
  a_abs_hit: assert property (p_abs_hit) else $error("missed absolute sense"); // R6 R7 R9

  property p_rel;
    @(posedge clk_i) disable iff (!reset_n_i)
    abs_code == RGC_ABS_DISABLE && rel_code == 2'h1 && 9'(strength_db_i) >= 9'(strength_ref_db_i) + 9'd6
      |=> ##1 carrier_sense_o;
  endproperty
  a_rel: assert property (p_rel) else $error("missed relative sense"); // R5

  property p_prio;
    @(posedge clk_i) disable iff (!reset_n_i)
    psel_i && penable_i && pwrite_i && paddr_i == RGC_ADDR_PRIO_CS |=> stage_reduction_priority_o == $past(pwdata_i[6]);
  endproperty
  a_prio: assert property (p_prio) else $error("priority not written"); // R4

  property p_ag;
    @(posedge clk_i) disable iff (!reset_n_i)
    psel_i && penable_i && pwrite_i && paddr_i == RGC_ADDR_GAIN_LIMIT |=> amplifier_gain_ceiling_o == $past(pwdata_i[5:3]);
  endproperty
  a_ag: assert property (p_ag) else $error("amplifier ceiling not written"); // R2

  property p_err;
    @(posedge clk_i) disable iff (!reset_n_i)
    psel_i && penable_i && !known |-> pslverr_o && prdata_o == 32'h00000000;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");

  property p_rd_top;
    @(posedge clk_i) disable iff (!reset_n_i)
    psel_i && penable_i && !pwrite_i && paddr_i == RGC_ADDR_PRIO_CS |-> prdata_o[31:7] == 25'h0000000;
  endproperty
  a_rd_top: assert property (p_rd_top) else $error("carrier sense top bit read back"); // R10

  property p_rel_off;
    @(posedge clk_i) disable iff (!reset_n_i)
    rel_code == RGC_REL_OFF |=> !s_q.rel_hit;
  endproperty
  a_rel_off: assert property (p_rel_off) else $error("relative sense while disabled"); // R5

  property p_abs_dis;
    @(posedge clk_i) disable iff (!reset_n_i)
    abs_code == RGC_ABS_DISABLE |=> !s_q.abs_hit;
  endproperty
  a_abs_dis: assert property (p_abs_dis) else $error("absolute sense while disabled"); // R8
endmodule

// ==== rgc_top_tb.sv ====
`timescale 1ns/1ps
module rgc_top_tb
  import rgc_pkg::*;
();
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                  clk_i = 1'b0;
  logic                  reset_n_i = 1'b0;
  logic                  psel_i = 1'b0;
  logic                  penable_i = 1'b0;
  logic                  pwrite_i = 1'b0;
  logic [RGC_ADDR_W-1:0] paddr_i = '0;
  logic [31:0]           pwdata_i = '0;
  logic [31:0]           prdata_o;
  logic                  pready_o, pslverr_o, stage_reduction_priority_o, carrier_sense_o;
  logic [7:0]            strength_db_i = '0;
  logic [7:0]            strength_ref_db_i = '0;
  logic [7:0]            amplitude_target_db_o, thr, rf;
  logic [2:0]            digital_gain_max_step_o, amplifier_gain_ceiling_o;
  logic [1:0]            chk_kind = '0;
  logic                  chk_v = 1'b0;
  logic [31:0]           rnd = 32'h36c0583c;
  logic [32:0]           exp_q[$];
  int                    error_cnt = 0, check_count = 0, cyc = 0;
  localparam logic [7:0] TGT [8] = '{8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};

  always #4 clk_i = ~clk_i;

  rgc_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .strength_db_i(strength_db_i),
    .strength_ref_db_i(strength_ref_db_i), .digital_gain_max_step_o(digital_gain_max_step_o),
    .amplifier_gain_ceiling_o(amplifier_gain_ceiling_o),
    .stage_reduction_priority_o(stage_reduction_priority_o),
    .amplitude_target_db_o(amplitude_target_db_o), .carrier_sense_o(carrier_sense_o));

  // ----------------------------------------
  // Comparison and verdict
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_sim();
    if (error_cnt == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] s);
    check_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cmp_rd(input logic [32:0] e); cmp("read", e, {pslverr_o, prdata_o}); endtask
  task automatic cmp_cs(input logic [32:0] e); cmp("carrier_sense", e, {32'h0, carrier_sense_o}); endtask
  task automatic cmp_cfg(input logic [32:0] e);
    cmp("config", e, {18'h0, digital_gain_max_step_o, amplifier_gain_ceiling_o,
      stage_reduction_priority_o, amplitude_target_db_o});
  endtask

  // Sampled on the falling edge so registered outputs have settled
  always @(negedge clk_i)
  begin
    if (chk_v)
      case (chk_kind)
        2'd1: cmp_cfg(exp_q.pop_front());
        default: cmp_cs(exp_q.pop_front());
      endcase
  end

  // Read answers are taken at the edge that finds the access phase with ready high
  always @(posedge clk_i)
  begin
    if (psel_i && penable_i && pready_o && !pwrite_i)
      cmp_rd(exp_q.pop_front());
  end

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic note(input logic [1:0] k, input logic [32:0] e);
    exp_q.push_back(e);
    chk_kind <= k;
    chk_v <= 1'b1;
    @(posedge clk_i);
    chk_v <= 1'b0;
  endtask

  // Read expectation is queued before the request; the monitor takes it at the ready edge
  task automatic apb(input logic wr, input logic [RGC_ADDR_W-1:0] a, input logic [7:0] d, input logic [32:0] e);
    if (!wr)
      exp_q.push_back(e);
    @(posedge clk_i);
    rnd = lfsr(rnd);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {rnd[31:8], d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [RGC_ADDR_W-1:0] a, input logic [7:0] d); apb(1'b1, a, d, '0); endtask
  task automatic rd(input logic [RGC_ADDR_W-1:0] a, input logic [7:0] d); apb(1'b0, a, 8'h00, {25'h0, d}); endtask

  // Four cycles cover the two-cycle sense latency with margin
  task automatic cs_chk(input logic [7:0] s, input logic [7:0] r, input logic e);
    strength_db_i <= s;
    strength_ref_db_i <= r;
    repeat (4) @(posedge clk_i);
    note(2'd2, {32'h0, e});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(RGC_ADDR_BIT_SYNC, RGC_RST_BIT_SYNC);
    rd(RGC_ADDR_GAIN_LIMIT, RGC_RST_GAIN_LIMIT);
    rd(RGC_ADDR_PRIO_CS, RGC_RST_PRIO_CS);
    note(2'd1, {18'h0, 3'd7, 3'd0, 1'b1, 8'h21});
    apb(1'b0, RGC_ADDR_PRIO_CS + 18'h4, 8'h00, {1'b1, 32'h0});
    for (int i = 0; i < 8; i++)
    begin
      wr(RGC_ADDR_GAIN_LIMIT, {i[1:0], 3'(7 - i), i[2:0]});
      rd(RGC_ADDR_GAIN_LIMIT, {i[1:0], 3'(7 - i), i[2:0]});
      note(2'd1, {18'h0, 3'(7 - i[1:0]), 3'(7 - i), 1'b1, TGT[i]});
    end
    wr(RGC_ADDR_PRIO_CS, 8'hff);
    rd(RGC_ADDR_PRIO_CS, 8'h7f);
    wr(RGC_ADDR_GAIN_LIMIT, 8'h03);
    for (int k = 0; k < 16; k++)
    begin
      wr(RGC_ADDR_PRIO_CS, {4'h0, k[3:0]});
      thr = 8'(33 + $signed(k[3:0]));
      if (k == 8)
        cs_chk(8'hff, 8'hff, 1'b0);
      else
      begin
        cs_chk(thr, 8'hff, 1'b1);
        cs_chk(thr - 8'h01, 8'hff, 1'b0);
      end
    end
    note(2'd1, {18'h0, 3'd7, 3'd0, 1'b0, 8'h21});
    for (int r = 0; r < 4; r++)
    begin
      rnd = lfsr(rnd);
      rf = {1'b0, rnd[6:0]};
      wr(RGC_ADDR_PRIO_CS, {2'b01, r[1:0], 4'h8});
      rd(RGC_ADDR_PRIO_CS, {2'b01, r[1:0], 4'h8});
      thr = rf + 8'(2 + 4 * r);
      cs_chk(r == 0 ? 8'hff : thr, rf, r != 0);
      cs_chk(thr - 8'h01, rf, 1'b0);
    end
    end_sim();
  end
endmodule
